/* File: tb/fws_ctrl_assertions.sv */
// pin and bus timing checks for the flash host controller
// assumes it is bound onto fws_ctrl and sees only its ports
`timescale 1ns/1ps
module fws_ctrl_assertions #(parameter AW = 22) (
  input wire clk, input wire reset,
  input wire psel, input wire penable, input wire pready, input wire pslverr,
  input wire [AW-1:0] fl_addr, input wire [15:0] fl_dq_out, input wire fl_dq_oe,
  input wire fl_ce_n, input wire fl_oe_n, input wire fl_we_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a strobe stays low for eleven clocks, then rises
  sequence low11(s);
    (!s)[*8] ##1 (!s)[*3] ##1 s;
  endsequence
  chk_we_len: assert property ($fell(fl_we_n) |-> low11(fl_we_n))
    else $error("write strobe length wrong");
  chk_oe_len: assert property ($fell(fl_oe_n) |-> low11(fl_oe_n))
    else $error("read strobe length wrong");
  chk_no_clash: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
    else $error("bus driven during read");
  chk_we_sel: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write without chip select");
  chk_hold_wr: assert property (!fl_we_n && $past(!fl_we_n) |->
    $stable(fl_addr) && $stable(fl_dq_out) && fl_dq_oe)
    else $error("write cycle not held");
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb wait state wrong");
  chk_rdy_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_rdy: assert property (pslverr |-> pready && $past(psel && penable))
    else $error("error without transfer");
endmodule
bind fws_ctrl fws_ctrl_assertions #(.AW(AW)) i_chk(.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n));

/* File: tb/fws_flash_model.sv */
// behavioural parallel flash with status bits on the data bus
// assumes pins sampled on clk; whole array erased, kept short on purpose
`timescale 1ns/1ps
`include "fws_defines.vh"
module fws_flash_model #(parameter AW = 22, parameter TMO = 500, parameter ERS = 800) (
  input wire clk,
  input wire [AW-1:0] addr,
  input wire [15:0] din,
  output wire [15:0] dout,
  input wire ce_n, input wire oe_n, input wire we_n,
  output wire rb
);
  logic [15:0] mem[int]; // unwritten words read erased
  logic [15:0] q = 0, w, pd = 0;
  logic pw = 1, po = 1, pgm = 0, tl = 0, t1 = 0, t2 = 0;
  int md = 0, cnt = 0; // 0 read 1 program 2 window 3 erasing 4 suspended
  assign dout = oe_n ? ~q : q; // released bus shows no stale value
  assign rb = !(md inside {1, 2, 3});
  always @(posedge clk) begin
    pw <= we_n;
    po <= oe_n;
    if (md == 4) cnt <= cnt; // suspended erase keeps its remaining time
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      if (md == 3) mem.delete();
      cnt <= (md == 2) ? ERS : 0;
      md <= (md == 2) ? 3 : 0;
    end
    if (we_n && !pw && !ce_n) begin
      if (md == 3) begin
        if (din == `FWS_FC_SUSP) md <= 4;
      end else if (pgm) begin
        w = mem.exists(addr) ? mem[addr] : 16'hffff;
        mem[addr] = w & din;
        tl <= |(din & ~w);
        cnt <= |(din & ~w) ? 0 : 60;
        md <= 1;
        pd <= din;
        pgm <= 0;
      end else if (din == `FWS_FC_RST) begin
        md <= 0; cnt <= 0; tl <= 0;
      end else if (din == `FWS_FC_PROG) pgm <= 1;
      else if (din == `FWS_FC_SECT) begin md <= 2; cnt <= TMO; end
      else if (din == `FWS_FC_CHIP) begin md <= 3; cnt <= ERS; end
    end
    if (!oe_n && po && !ce_n) begin
      if (md inside {1, 2, 3, 4} || tl) begin
        if (md != 4) t1 <= ~t1;
        if (md != 1) t2 <= ~t2;
        q <= {8'h00, md == 1 ? ~pd[7] : md == 4, md != 4 ? ~t1 : t1, tl, 1'b0, md == 3,
          md != 1 ? ~t2 : t2, 2'b00};
      end else q <= mem.exists(addr) ? mem[addr] : 16'hffff;
    end
  end
endmodule

/* File: tb/tb_fws_ctrl.sv */
// self-checking bench for the flash write-status host controller
// assumes the flash model on the pins; software side driven over apb
`timescale 1ns/1ps
`include "fws_defines.vh"
module tb_fws_ctrl;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, rb, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, s;
  logic pready, pslverr, foe, ce, oe, we;
  logic [21:0] fa;
  logic [15:0] fo, fi, d, r = 16'h0047;
  logic [15:0] em[int]; // bench copy of the array
  int fails = 0, num_checks = 0, cyc = 0;
  fws_ctrl i_fws_ctrl(.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_addr(fa), .fl_dq_out(fo), .fl_dq_oe(foe), .fl_dq_in(fi),
    .fl_ce_n(ce), .fl_oe_n(oe), .fl_we_n(we), .ready_busy_output(rb));
  fws_flash_model i_fws_flash_model(.clk(clk), .addr(fa), .din(fo), .dout(fi),
    .ce_n(ce), .oe_n(oe), .we_n(we), .rb(rb));
  initial forever #2 clk = ~clk;
  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] v, input logic [31:0] x);
    num_checks++;
    if (v !== x) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, x, v);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= dd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // issue a command and wait until the controller is idle
  task automatic cmd(input logic [2:0] c, input logic [21:0] a, input logic [15:0] dd);
    apb(1, `FWS_REG_ADDR, {10'h000, a});
    apb(1, `FWS_REG_DATA, {16'h0000, dd});
    apb(1, `FWS_REG_CMD, {29'h0, c});
    s = 1;
    while (s[0] !== 1'b0) begin
      apb(0, `FWS_REG_STAT, 0);
      s = q;
    end
  endtask
  task automatic done(input logic [21:0] a);
    repeat (40) begin
      cmd(`FWS_OP_READ, a, 0);
      cmd(`FWS_OP_READ, a, 0);
      if (s[2] === 1'b0) break;
    end
    chk("op done", s[2], 0);
  endtask
  task automatic rd(input int a);
    cmd(`FWS_OP_READ, a[21:0], 0);
    apb(0, `FWS_REG_RDAT, 0);
    chk("rdat", q, {16'h0000, em.exists(a) ? em[a] : 16'hffff});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 0;
    apb(0, `FWS_REG_STAT, 0); chk("idle", q[0], 0);
    apb(0, 12'h020, 0); chk("unmap err", e, 1);
    chk("unmap data", q, 0);
    r = lf(r);
    d = r & 16'h7ffe;
    em[256] = d;
    cmd(`FWS_OP_PROG, 256, d); chk("pgm tlim", s[3], 0);
    done(256); rd(256);
    cmd(`FWS_OP_PROG, 256, 16'hffff);
    cmd(`FWS_OP_READ, 256, 0); chk("tlim set", s[3], 1);
    cmd(`FWS_OP_READ, 256, 0); chk("tlim held", s[3], 1);
    chk("still toggling", s[2], 1);
    cmd(`FWS_OP_RESET, 0, 0); rd(256);
    chk("tlim clear", s[3], 0);
    cmd(`FWS_OP_SERASE, 256, 0); chk("timer low", s[4], 0);
    cmd(`FWS_OP_SERASE, 22'h008000, 0); chk("extra taken", s[6], 0);
    repeat (410) @(posedge clk);
    cmd(`FWS_OP_READ, 256, 0); chk("timer restart", s[4], 0);
    repeat (300) @(posedge clk);
    cmd(`FWS_OP_READ, 256, 0); chk("timer high", s[4], 1);
    chk("erase busy pin", s[1], 1);
    chk("erase flag", s[7], 1);
    chk("sector toggle", s[5], 1);
    cmd(`FWS_OP_SERASE, 22'h010000, 0); chk("late sector", s[6], 1);
    cmd(`FWS_OP_PROG, 512, 16'h0000);
    em.delete();
    done(256); rd(512);
    chk("erase over", s[7], 0);
    rd(256);
    cmd(`FWS_OP_CERASE, 0, 0); chk("chip no timer", s[4], 1);
    cmd(`FWS_OP_SUSP, 0, 0); chk("suspend ready", s[1], 0);
    cmd(`FWS_OP_RESET, 0, 0);
    done(0);
    close_out;
  end
endmodule

/* File: verilog/fws_ctrl.v */
// host controller that drives a parallel flash and reports write status
// assumes flash pins synchronous to clk; software uses apb registers
// Function
// - host issues reset after time-limit failure
// - fast hosts may skip timer monitoring
// - confirm acceptance before reading timer flag
// - check timer flag before and after
// - host gives valid address for status
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "fws_defines.vh"
module fws_ctrl #(
  parameter AW = 22,
  parameter PH = `FWS_PH_CYC
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // flash pins
  output reg [AW-1:0] fl_addr,
  output reg [15:0] fl_dq_out,
  output reg fl_dq_oe,
  input wire [15:0] fl_dq_in,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n,
  input wire ready_busy_output
);
  // sequencer states
  // write and read each run setup, strobe-low and end phases
  localparam S_IDLE = 3'h0;
  localparam S_WSET = 3'h1;
  localparam S_WLOW = 3'h2;
  localparam S_WEND = 3'h3;
  localparam S_RSET = 3'h4;
  localparam S_RLOW = 3'h5;
  localparam S_REND = 3'h6;
  // sequencer state and counters
  reg [2:0] st_q;
  reg [7:0] cnt_q; // phase counter
  reg [2:0] nwr_q; // writes left in sequence
  reg [2:0] op_q; // active command
  reg [AW-1:0] addr_q; // software target address
  reg [15:0] data_q; // software program data
  reg [15:0] rdat_q; // last read word
  reg [15:0] prev_q; // previous word read from the flash
  reg prev_ok_q; // prev_q holds a word read since the last write sequence
  reg busy_q; // sequencer running
  reg tog1_q; // toggle_bit_one toggled on last pair
  reg tog2_q; // toggle_bit_two toggled
  reg tlim_q; // sticky timing_limit_flag seen
  reg etmr_q; // erase_timer_flag last seen
  reg rej_q; // extra sector may have been rejected
  reg ebusy_q; // erase in progress from host view
  reg pre_etmr_q; // timer flag sampled before extra sector
  // one word of each multi-write command
  // the unlock pair leads every program and erase sequence
  reg [AW-1:0] sa;
  reg [15:0] sd;
  always @* begin
    sa = `FWS_UA1;
    sd = `FWS_FC_UNLK1;
    case (op_q)
      `FWS_OP_PROG: begin
        case (nwr_q)
          3'h4: begin sa = `FWS_UA1; sd = `FWS_FC_UNLK1; end
          3'h3: begin sa = `FWS_UA2; sd = `FWS_FC_UNLK2; end
          3'h2: begin sa = `FWS_UA1; sd = `FWS_FC_PROG; end
          default: begin sa = addr_q; sd = data_q; end
        endcase
      end
      `FWS_OP_SERASE, `FWS_OP_CERASE: begin
        case (nwr_q)
          3'h6: begin sa = `FWS_UA1; sd = `FWS_FC_UNLK1; end
          3'h5: begin sa = `FWS_UA2; sd = `FWS_FC_UNLK2; end
          3'h4: begin sa = `FWS_UA1; sd = `FWS_FC_ERS; end
          3'h3: begin sa = `FWS_UA1; sd = `FWS_FC_UNLK1; end
          3'h2: begin sa = `FWS_UA2; sd = `FWS_FC_UNLK2; end
          default: begin
            // chip erase has no sector timer
            sa = (op_q == `FWS_OP_SERASE) ? addr_q : `FWS_UA1;
            sd = (op_q == `FWS_OP_SERASE) ? `FWS_FC_SECT : `FWS_FC_CHIP;
          end
        endcase
      end
      `FWS_OP_SUSP: begin sa = addr_q; sd = `FWS_FC_SUSP; end
      default: begin sa = addr_q; sd = `FWS_FC_RST; end
    endcase
  end
  // apb access decode
  // pready high marks the answer cycle, so it blocks a second take
  wire acc = psel && penable && !pready;
  wire wr_cmd = acc && pwrite && (paddr == `FWS_REG_CMD);
  // command code sits in the low bits of the write word
  wire [2:0] new_op = pwdata[2:0];
  // write-count per op
  reg [2:0] nwr_d;
  always @* begin
    case (new_op)
      `FWS_OP_PROG: nwr_d = 3'h4;
      `FWS_OP_SERASE: nwr_d = 3'h6;
      `FWS_OP_CERASE: nwr_d = 3'h6;
      // reads and single-word commands take one pass
      default: nwr_d = 3'h1;
    endcase
  end
  // flash data pins, already synchronous to clk
  wire [15:0] dq = fl_dq_in;
  // a word counts as status after a command, or while the flash pin says busy;
  // a plain read of a ready flash returns array data, which must not touch tlim_q, etmr_q or rej_q
  wire st_read = (op_q != `FWS_OP_READ) || !ready_busy_output;
  // apb slave: one-wait answer, busy refusal via pslverr
  always @(posedge clk) begin
    if (reset) begin
      // bus side idle after reset
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      addr_q <= {AW{1'b0}};
      data_q <= 16'h0;
    end else begin
      // every access answers after exactly one wait state
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      // writes land on the first access edge
      if (acc && pwrite) begin
        if (paddr == `FWS_REG_ADDR)
          addr_q <= pwdata[AW-1:0];
        else if (paddr == `FWS_REG_DATA)
          data_q <= pwdata[15:0];
        else if (paddr == `FWS_REG_CMD)
          pslverr <= busy_q; // busy sequencer refuses new command
        else
          pslverr <= 1'b1;
      end else if (acc) begin
        // reads register their data for the ready cycle
        case (paddr)
          `FWS_REG_ADDR: prdata <= {{(32-AW){1'b0}}, addr_q};
          `FWS_REG_DATA: prdata <= {16'h0, data_q};
          `FWS_REG_RDAT: prdata <= {16'h0, rdat_q};
          `FWS_REG_STAT: prdata <= {24'h0, ebusy_q, rej_q, tog2_q, etmr_q, tlim_q,
            tog1_q, !ready_busy_output, busy_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // flash strobe sequencer
  always @(posedge clk) begin
    if (reset) begin
      // sequencer parked
      st_q <= S_IDLE;
      cnt_q <= 8'h0;
      nwr_q <= 3'h0;
      op_q <= 3'h0;
      busy_q <= 1'b0;
      // flash pins parked, all strobes high
      fl_addr <= {AW{1'b0}};
      fl_dq_out <= 16'h0;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      // status history forgotten
      rdat_q <= 16'h0;
      prev_q <= 16'h0;
      prev_ok_q <= 1'b0;
      tog1_q <= 1'b0;
      tog2_q <= 1'b0;
      tlim_q <= 1'b0;
      etmr_q <= 1'b0;
      rej_q <= 1'b0;
      ebusy_q <= 1'b0;
      pre_etmr_q <= 1'b0;
    end else begin
      // one state per strobe phase
      case (st_q)
        S_IDLE: begin
          // wait for a command write from software
          fl_ce_n <= 1'b1;
          if (wr_cmd && !busy_q) begin
            busy_q <= 1'b1;
            op_q <= new_op;
            nwr_q <= nwr_d;
            cnt_q <= 8'h0;
            if (new_op == `FWS_OP_READ) begin
              st_q <= S_RSET;
            end else begin
              st_q <= S_WSET;
              // timer flag before an extra sector
              if (new_op == `FWS_OP_SERASE)
                pre_etmr_q <= etmr_q && ebusy_q;
              if (new_op == `FWS_OP_RESET) begin
                tlim_q <= 1'b0; // failure cleared by reset command
                ebusy_q <= 1'b0;
                prev_ok_q <= 1'b0;
              end
            end
          end else begin
            // nothing pending: report idle
            busy_q <= 1'b0;
          end
        end
        S_WSET: begin
          // address and data settle one clock before the strobe falls
          fl_addr <= sa;
          fl_dq_out <= sd;
          fl_dq_oe <= 1'b1;
          fl_ce_n <= 1'b0;
          cnt_q <= 8'h0;
          st_q <= S_WLOW;
        end
        S_WLOW: begin
          // write strobe low for PH+1 clocks
          fl_we_n <= 1'b0;
          cnt_q <= cnt_q + 8'h1;
          if (cnt_q == PH[7:0])
            st_q <= S_WEND;
        end
        S_WEND: begin
          // strobe rises; the last word ends the sequence
          fl_we_n <= 1'b1;
          nwr_q <= nwr_q - 3'h1;
          if (nwr_q == 3'h1) begin
            fl_dq_oe <= 1'b0;
            prev_ok_q <= 1'b0;
            if (op_q == `FWS_OP_SERASE || op_q == `FWS_OP_CERASE)
              ebusy_q <= 1'b1;
            // acceptance is confirmed by a following status read, except after a reset command
            st_q <= (op_q == `FWS_OP_RESET) ? S_IDLE : S_RSET;
            op_q <= (op_q == `FWS_OP_RESET) ? op_q : op_q;
          end else begin
            st_q <= S_WSET;
          end
          cnt_q <= 8'h0;
        end
        S_RSET: begin
          // release the data bus before the read strobe falls
          fl_addr <= addr_q; // valid status address
          fl_dq_oe <= 1'b0;
          fl_ce_n <= 1'b0;
          cnt_q <= 8'h0;
          st_q <= S_RLOW;
        end
        S_RLOW: begin
          // read strobe low long enough for the flash access time
          fl_oe_n <= 1'b0;
          cnt_q <= cnt_q + 8'h1;
          if (cnt_q == PH[7:0])
            st_q <= S_REND;
        end
        default: begin
          // sample word at end of read strobe
          fl_oe_n <= 1'b1;
          rdat_q <= dq;
          prev_q <= dq;
          prev_ok_q <= 1'b1;
          st_q <= S_IDLE;
          busy_q <= 1'b0;
          // a broken history must not fake a toggle
          if (prev_ok_q) begin
            // busy reads show toggling bit six
            tog1_q <= dq[`FWS_DQ_TOG1] ^ prev_q[`FWS_DQ_TOG1];
            // erasing sectors toggle bit two
            tog2_q <= dq[`FWS_DQ_TOG2] ^ prev_q[`FWS_DQ_TOG2];
          end
          if (st_read) begin
            // sticky failure flag
            if (dq[`FWS_DQ_TLIM])
              tlim_q <= 1'b1;
            // timer flag watched on every status read, no fast-host shortcut
            etmr_q <= dq[`FWS_DQ_ETMR];
            // after-check of extra sector
            if (op_q == `FWS_OP_SERASE)
              rej_q <= pre_etmr_q || (dq[`FWS_DQ_ETMR] && rej_q);
          end
          // polling bit one, or array data on a ready flash, ends erase
          if (ready_busy_output && !tlim_q && (dq[`FWS_DQ_POLL] || !st_read))
            ebusy_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: verilog/fws_defines.vh */
// constants for the flash write-status host controller
// assumes a 16-bit parallel flash with toggle/polling status bits
`ifndef FWS_DEFINES_VH
`define FWS_DEFINES_VH
// apb register byte offsets
`define FWS_REG_CMD 12'h000
`define FWS_REG_ADDR 12'h004
`define FWS_REG_DATA 12'h008
`define FWS_REG_STAT 12'h00c
`define FWS_REG_RDAT 12'h010
// command codes written to the command register
`define FWS_OP_PROG 3'h1
`define FWS_OP_SERASE 3'h2
`define FWS_OP_CERASE 3'h3
`define FWS_OP_SUSP 3'h4
`define FWS_OP_RESET 3'h5
`define FWS_OP_READ 3'h6
// status bit positions on the flash data bus
`define FWS_DQ_POLL 7
`define FWS_DQ_TOG1 6
`define FWS_DQ_TLIM 5
`define FWS_DQ_ETMR 3
`define FWS_DQ_TOG2 2
// flash command bytes
`define FWS_FC_UNLK1 16'h00aa
`define FWS_FC_UNLK2 16'h0055
`define FWS_FC_PROG 16'h00a0
`define FWS_FC_ERS 16'h0080
`define FWS_FC_SECT 16'h0030
`define FWS_FC_CHIP 16'h0010
`define FWS_FC_SUSP 16'h00b0
`define FWS_FC_RST 16'h00f0
`define FWS_UA1 22'h000555
`define FWS_UA2 22'h0002aa
// strobe phase length in clocks (4 ns each)
`define FWS_PH_NS 40
`define FWS_PH_CYC ((`FWS_PH_NS + 3) / 4)
`endif
